// File: verilog/bpp_defs.svh
// Register offsets, reset values and timing counts for the port pin control block
`ifndef BPP_DEFS_SVH
`define BPP_DEFS_SVH

// ==========================================
// Register offsets (byte addresses)
`define BPP_ADDR_W          4
`define BPP_OFF_DIRECTION   4'h0
`define BPP_OFF_FUNC_SEL    4'h4
`define BPP_OFF_OUT_DATA    4'h8
`define BPP_OFF_IN_SAMPLE   4'hC

// ==========================================
// Reset values
`define BPP_RST_DIRECTION   8'hFF
`define BPP_RST_FUNC_SEL    8'h00
`define BPP_RST_OUT_DATA    8'hFF
`define BPP_RST_UNMAPPED    8'h00

// ==========================================
// Timing
`define BPP_CLK_PERIOD_NS   20
`define BPP_STRONG_PULL_NS  300
`define BPP_STRONG_PULL_CYC \
  ((`BPP_STRONG_PULL_NS + `BPP_CLK_PERIOD_NS - 1) / `BPP_CLK_PERIOD_NS)

// ==========================================
// Clock output pin position
`define BPP_SYSTEM_CLOCK_OUTPUT_BIT      7

`endif

// File: verilog/bpp_pkg.sv
// Types shared by the port pin control block
package bpp_pkg;

  typedef enum logic [1:0] {
    BPP_RD_DIRECTION = 2'b00,
    BPP_RD_FUNC_SEL  = 2'b01,
    BPP_RD_OUT_DATA  = 2'b10,
    BPP_RD_IN_SAMPLE = 2'b11
  } bpp_reg_sel_type;

endpackage

// File: verilog/bpp_port_ctrl.sv
// Per-pin drive control, input sampling and register port of a bidirectional port
//
// Function
// R1: Select bit 0: drivers follow software data and direction bits.
// R2: Select bit 1: drivers follow peripheral direction and data.
// R3: Peripheral outputs present direction 0, peripheral inputs present 1.
// R4: Software complementary mode: data 0 pulls down, data 1 pulls up.
// R5: Software open-drain mode: no pull-up, data 0 pulls down, 1 floats.
// R6: Peripheral complementary mode follows peripheral data, ignores software data.
// R7: Peripheral open-drain mode: no pull-up, pull-down on peripheral data 0.
// R8: Software sets direction and data to 1 for input pins.
// R9: Pin levels sampled and readable in every configuration.
// R10: Strong pull-high for about 300 ns when reset falls.
// R11: Weak pull-up during reset until first function-select write.
// R12: Reset values give high-impedance inputs with weak pull-up.
// R13: Optional variant drives bit 7 of port 2 as complementary clock output; here only until the first function-select write.
// R14: Each pin configured independently of the others.
// R15: Software writes direction, then function select, then output data.
// R16: Software writes direction and data even for peripheral pins.
// R17: Registers 8 bits, bit y is pin y, writes reach pin next clock.
`timescale 1ns/1ns
`include "bpp_defs.svh"

module bpp_port_ctrl #(
  parameter int WIDTH          = 8,   // Pins in the port
  parameter bit SYSTEM_CLOCK_OUTPUT_ON_BIT7 = 1'b0 // Clock output variant on bit 7
) (
  input  wire logic                   core_clk,        // Core clock, 50 MHz
  input  wire logic                   rst_n,           // Synchronous reset, active low
  input  wire logic [`BPP_ADDR_W-1:0] reg_addr,        // Register byte address
  input  wire logic [7:0]             reg_wdata,       // Write data
  input  wire logic                   reg_wr,          // Write strobe
  input  wire logic                   reg_rd,          // Read strobe
  output logic      [7:0]             reg_rdata,       // Read data, cycle after strobe
  input  wire logic [WIDTH-1:0]       peripheral_direction,    // Peripheral direction
  input  wire logic [WIDTH-1:0]       peripheral_output_value, // Peripheral data
  input  wire logic                   system_clock_output,     // Half-crystal clock
  input  wire logic [WIDTH-1:0]       pin_in,          // Pin levels, asynchronous
  output logic      [WIDTH-1:0]       pull_up_on,      // Pull-up transistor gate
  output logic      [WIDTH-1:0]       pull_down_on,    // Pull-down transistor gate
  output logic      [WIDTH-1:0]       strong_high_on,  // Strong pull-high gate
  output logic      [WIDTH-1:0]       weak_up_on       // Weak pull-up gate
);

  // ==========================================
  // Elaboration checks
  localparam int STRONG_CYC = `BPP_STRONG_PULL_CYC;
  localparam int CNT_W      = $clog2(STRONG_CYC + 1);
  localparam int REG_W      = 8;

  initial begin
    if (WIDTH < 1 || WIDTH > REG_W) begin
      $error("bpp_port_ctrl: WIDTH must be 1 to 8");
    end
    if (SYSTEM_CLOCK_OUTPUT_ON_BIT7 && WIDTH <= `BPP_SYSTEM_CLOCK_OUTPUT_BIT) begin
      $error("bpp_port_ctrl: clock output variant needs bit 7");
    end
    if (STRONG_CYC < 1) begin
      $error("bpp_port_ctrl: strong pull pulse needs at least one cycle");
    end
    if (`BPP_ADDR_W < 4) begin
      $error("bpp_port_ctrl: address too narrow for the register map");
    end
  end

  // ==========================================
  // Register decode
  function automatic logic hit(input logic [`BPP_ADDR_W-1:0] a,
                               input logic [`BPP_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic mapped(input logic [`BPP_ADDR_W-1:0] a);
    mapped = hit(a, `BPP_OFF_DIRECTION) || hit(a, `BPP_OFF_FUNC_SEL) ||
             hit(a, `BPP_OFF_OUT_DATA)  || hit(a, `BPP_OFF_IN_SAMPLE);
  endfunction

  // Only meaningful for mapped addresses
  function automatic bpp_pkg::bpp_reg_sel_type sel_of(input logic [`BPP_ADDR_W-1:0] a);
    if (hit(a, `BPP_OFF_DIRECTION)) begin
      sel_of = bpp_pkg::BPP_RD_DIRECTION;
    end else if (hit(a, `BPP_OFF_FUNC_SEL)) begin
      sel_of = bpp_pkg::BPP_RD_FUNC_SEL;
    end else if (hit(a, `BPP_OFF_OUT_DATA)) begin
      sel_of = bpp_pkg::BPP_RD_OUT_DATA;
    end else begin
      sel_of = bpp_pkg::BPP_RD_IN_SAMPLE;
    end
  endfunction

  function automatic logic [7:0] widen(input logic [WIDTH-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[WIDTH-1:0] = v;
    widen = r;
  endfunction

  // Pins handed to the clock output variant; empty when the variant is off
  function automatic logic [WIDTH-1:0] clk_mask();
    logic [7:0] m;
    m = 8'h00;
    if (SYSTEM_CLOCK_OUTPUT_ON_BIT7) begin
      m[`BPP_SYSTEM_CLOCK_OUTPUT_BIT] = 1'b1;
    end
    clk_mask = m[WIDTH-1:0];
  endfunction

  localparam logic [WIDTH-1:0] CLK_PINS = clk_mask();

  // Per-pin gate decode, returns {pull-up, pull-down}
  function automatic logic [1:0] gates(input logic sel,
                                       input logic dir_sw,
                                       input logic dat_sw,
                                       input logic dir_pf,
                                       input logic dat_pf);
    logic dir;
    logic dat;
    dir   = sel ? dir_pf : dir_sw;                                     // R1 R2 R3
    dat   = sel ? dat_pf : dat_sw;                                     // R1 R6 R7
    gates = {!dir && dat, !dat};                                       // R4 R5 R7
  endfunction

  // Saturating count-down for the pulse counter
  function automatic logic [CNT_W-1:0] sat_dec(input logic [CNT_W-1:0] c);
    sat_dec = (c == '0) ? '0 : c - CNT_W'(1);
  endfunction

  // ==========================================
  // Control registers
  // Writes to unmapped addresses match no enable and are lost
  logic [WIDTH-1:0] direction_q;
  logic [WIDTH-1:0] func_sel_q;
  logic [WIDTH-1:0] out_data_q;
  logic             wr_dir;
  logic             wr_sel;
  logic             wr_dat;

  assign wr_dir = reg_wr && hit(reg_addr, `BPP_OFF_DIRECTION);
  assign wr_sel = reg_wr && hit(reg_addr, `BPP_OFF_FUNC_SEL);
  assign wr_dat = reg_wr && hit(reg_addr, `BPP_OFF_OUT_DATA);

  // Direction: 0 complementary output, 1 open drain or input
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      direction_q <= WIDTH'(`BPP_RST_DIRECTION);                       // R12
    end else if (wr_dir) begin
      direction_q <= reg_wdata[WIDTH-1:0];                             // R14
    end
  end

  // Function select: 0 software I/O, 1 peripheral
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      func_sel_q <= WIDTH'(`BPP_RST_FUNC_SEL);                         // R12
    end else if (wr_sel) begin
      func_sel_q <= reg_wdata[WIDTH-1:0];                              // R14
    end
  end

  // Output data, kept at 1 on pins used as inputs
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_data_q <= WIDTH'(`BPP_RST_OUT_DATA);                         // R12
    end else if (wr_dat) begin
      out_data_q <= reg_wdata[WIDTH-1:0];                              // R17
    end
  end

  // ==========================================
  // Weak pull-up: on in reset, off at first function-select write
  logic weak_q;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      weak_q <= 1'b1;                                                  // R11
    end else if (wr_sel) begin
      weak_q <= 1'b0;                                                  // R11
    end
  end

  // ==========================================
  // Strong pull-high pulse
  // Loaded at the first edge that sees reset low and counted down from there, in reset or
  // after release, so the pulse length does not depend on how long reset is held.
  // Power-up, with no reset history yet, takes the load branch as well.
  logic             rst_low_q;
  logic [CNT_W-1:0] strong_cnt_q;
  logic [CNT_W-1:0] strong_cnt_d;

  always_ff @(posedge core_clk) begin
    rst_low_q <= !rst_n;
  end

  always_comb begin
    strong_cnt_d = sat_dec(strong_cnt_q);                              // R10
    if (!rst_n) begin
      if (rst_low_q) begin
        strong_cnt_d = sat_dec(strong_cnt_q);                          // R10
      end else begin
        strong_cnt_d = CNT_W'(STRONG_CYC);                             // R10
      end
    end
  end

  always_ff @(posedge core_clk) begin
    strong_cnt_q <= strong_cnt_d;                                      // R10
  end

  // ==========================================
  // Pin sampling: two flops, then the sample register
  // Only the second flop may read the first one
  logic [WIDTH-1:0] pin_meta_q;
  logic [WIDTH-1:0] pin_sync_q;
  logic [WIDTH-1:0] in_sample_q;

  always_ff @(posedge core_clk) begin
    pin_meta_q <= pin_in;
  end

  always_ff @(posedge core_clk) begin
    pin_sync_q <= pin_meta_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in_sample_q <= '0;
    end else begin
      in_sample_q <= pin_sync_q;                                       // R9
    end
  end

  // ==========================================
  // Read port
  // Read data stand for one cycle and return to zero after it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd && mapped(reg_addr)) begin
      unique case (sel_of(reg_addr))
        bpp_pkg::BPP_RD_DIRECTION: reg_rdata <= widen(direction_q);   // R17
        bpp_pkg::BPP_RD_FUNC_SEL:  reg_rdata <= widen(func_sel_q);    // R17
        bpp_pkg::BPP_RD_OUT_DATA:  reg_rdata <= widen(out_data_q);    // R17
        bpp_pkg::BPP_RD_IN_SAMPLE: reg_rdata <= widen(in_sample_q);   // R9
      endcase
    end else if (reg_rd) begin
      reg_rdata <= `BPP_RST_UNMAPPED;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================
  // Drive decode
  // Function select picks the source per pin; direction 1 never pulls up, except on the clock output pin
  logic [WIDTH-1:0] up_d;
  logic [WIDTH-1:0] down_d;

  always_comb begin
    up_d   = '0;
    down_d = '0;
    for (int y = 0; y < WIDTH; y++) begin
      {up_d[y], down_d[y]} = gates(func_sel_q[y],
                                   direction_q[y],
                                   out_data_q[y],
                                   peripheral_direction[y],
                                   peripheral_output_value[y]);        // R14
    end
    // Clock output owns its pin until the first function-select write
    if (weak_q) begin
      up_d   = (up_d & ~CLK_PINS) | ({WIDTH{system_clock_output}} & CLK_PINS);   // R13
      down_d = (down_d & ~CLK_PINS) | ({WIDTH{!system_clock_output}} & CLK_PINS); // R13
    end
  end

  // ==========================================
  // Pin gate outputs, all registered
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pull_up_on <= '0;
    end else begin
      pull_up_on <= up_d;                                              // R17
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pull_down_on <= '0;
    end else begin
      pull_down_on <= down_d;                                          // R17
    end
  end

  always_ff @(posedge core_clk) begin
    strong_high_on <= {WIDTH{strong_cnt_d != '0}};                     // R10
  end

  always_ff @(posedge core_clk) begin
    weak_up_on <= {WIDTH{weak_q || !rst_n}} & ~CLK_PINS;               // R11 R13
  end

endmodule // bpp_port_ctrl

// File: bench/bpp_monitor.sv
// Port-level assertions for the port pin control block
`timescale 1ns/1ns
`include "bpp_defs.svh"
module bpp_monitor #(parameter int WIDTH = 8) (
  input wire logic             core_clk,                // Clock
  input wire logic             rst_n,                   // Reset
  input wire logic [3:0]       reg_addr,                // Address
  input wire logic [7:0]       reg_wdata,               // Write data
  input wire logic             reg_wr,                  // Write strobe
  input wire logic             reg_rd,                  // Read strobe
  input wire logic [7:0]       reg_rdata,               // Read data
  input wire logic [WIDTH-1:0] peripheral_direction,    // Peripheral direction
  input wire logic [WIDTH-1:0] peripheral_output_value, // Peripheral data
  input wire logic [WIDTH-1:0] pin_in,                  // Pins
  input wire logic [WIDTH-1:0] pull_up_on,              // Pull-up
  input wire logic [WIDTH-1:0] pull_down_on,            // Pull-down
  input wire logic [WIDTH-1:0] strong_high_on,          // Strong pull
  input wire logic [WIDTH-1:0] weak_up_on               // Weak pull
);
  // ==========
  // Register shadow
  logic [7:0] dir_q, sel_q, dat_q;
  logic [4:0] cnt_q;
  wire logic [7:0] exp_up = (sel_q & ~peripheral_direction & peripheral_output_value)
                            | (~sel_q & ~dir_q & dat_q);
  wire logic [7:0] exp_dn = (sel_q & ~peripheral_output_value) | (~sel_q & ~dat_q);
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dir_q <= `BPP_RST_DIRECTION;
      sel_q <= `BPP_RST_FUNC_SEL;
      dat_q <= `BPP_RST_OUT_DATA;
    end else if (reg_wr) begin
      if (reg_addr == `BPP_OFF_DIRECTION) dir_q <= reg_wdata;
      if (reg_addr == `BPP_OFF_FUNC_SEL) sel_q <= reg_wdata;
      if (reg_addr == `BPP_OFF_OUT_DATA) dat_q <= reg_wdata;
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) cnt_q <= 5'h00;
    else if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
  end
  // ==========
  // Assertions
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_up; pull_up_on == $past(exp_up); endproperty
  a_up: assert property (p_up) else $error("pull-up mismatch");
  property p_dn; pull_down_on == $past(exp_dn); endproperty
  a_dn: assert property (p_dn) else $error("pull-down mismatch");
  property p_wk; reg_wr && reg_addr == `BPP_OFF_FUNC_SEL |-> ##2 weak_up_on == '0; endproperty
  a_wk: assert property (p_wk) else $error("weak pull not cleared");
  property p_wf; $fell(|weak_up_on) |-> $past(reg_wr && reg_addr == `BPP_OFF_FUNC_SEL, 2);
  endproperty
  a_wf: assert property (p_wf) else $error("weak pull cleared early");
  property p_st; cnt_q >= 5'h0F |-> strong_high_on == '0; endproperty
  a_st: assert property (p_st) else $error("strong pull too long");
  property p_smp; ($stable(pin_in)[*4] ##0 reg_rd && reg_addr == `BPP_OFF_IN_SAMPLE)
    |=> reg_rdata == 8'($past(pin_in)); endproperty
  a_smp: assert property (p_smp) else $error("sample mismatch");
  property p_un; reg_rd && !(reg_addr inside {`BPP_OFF_DIRECTION, `BPP_OFF_FUNC_SEL,
    `BPP_OFF_OUT_DATA, `BPP_OFF_IN_SAMPLE}) |=> reg_rdata == 8'h00; endproperty
  a_un: assert property (p_un) else $error("unmapped read not zero");
  property p_dr; reg_rd && reg_addr == `BPP_OFF_DIRECTION |=> reg_rdata == $past(dir_q);
  endproperty
  a_dr: assert property (p_dr) else $error("direction read mismatch");
endmodule // bpp_monitor

// File: bench/bpp_pin_model.sv
// Pin-side circuitry: resolves each pin level from the driver gates
`timescale 1ns/1ns
module bpp_pin_model (
  input  wire logic       core_clk,       // Clock
  input  wire logic [7:0] pull_up_on,     // Pull-up gates
  input  wire logic [7:0] pull_down_on,   // Pull-down gates
  input  wire logic [7:0] strong_high_on, // Strong pull gates
  input  wire logic [7:0] weak_up_on,     // Weak pull gates
  input  wire logic [7:0] ext_pull_up,    // Board pull-ups
  output logic      [7:0] pin_level       // Resolved pins
);
  logic [7:0] float_q = 8'h55;
  always @(posedge core_clk) float_q <= ~float_q;
  // Low driver wins; undriven pins without pull wander
  assign pin_level = ~pull_down_on & (pull_up_on | strong_high_on | weak_up_on
                     | ext_pull_up | float_q);
endmodule // bpp_pin_model

// File: bench/tb_top.sv
// Self-checking bench for the port pin control block
`timescale 1ns/1ns
`include "bpp_defs.svh"
module tb_top;
  logic       core_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, pdir = 8'hFF, pval = 8'hFF, pin_in, reg_rdata;
  logic [7:0] pull_up_on, pull_down_on, strong_high_on, weak_up_on;
  integer     num_errors = 0, checked = 0, seed = 56361, i, m_dir, m_sel, m_dat, m_weak;
  always #10 core_clk = ~core_clk;
  bpp_port_ctrl uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .peripheral_direction(pdir), .peripheral_output_value(pval), .system_clock_output(1'b0),
    .pin_in(pin_in), .pull_up_on(pull_up_on), .pull_down_on(pull_down_on),
    .strong_high_on(strong_high_on), .weak_up_on(weak_up_on));
  bpp_pin_model pins_m (.core_clk(core_clk), .pull_up_on(pull_up_on),
    .pull_down_on(pull_down_on), .strong_high_on(strong_high_on), .weak_up_on(weak_up_on),
    .ext_pull_up(8'hFF), .pin_level(pin_in));
  task automatic summarize;
    $display("errors=%0d checks=%0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input integer d);
    reg_addr <= a;
    reg_wdata <= d[7:0];
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    if (a == `BPP_OFF_DIRECTION) m_dir = d;
    if (a == `BPP_OFF_OUT_DATA) m_dat = d;
    if (a == `BPP_OFF_FUNC_SEL) m_sel = d;
    if (a == `BPP_OFF_FUNC_SEL) m_weak = 0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input integer e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e[7:0]);
    @(posedge core_clk);
  endtask
  task automatic pins;
    integer eu, ed;
    repeat (5) @(posedge core_clk);
    eu = (m_sel & ~pdir & pval) | (~m_sel & ~m_dir & m_dat);
    ed = (m_sel & ~pval) | (~m_sel & ~m_dat);
    @(negedge core_clk);
    chk(pull_up_on, eu[7:0]);
    chk(pull_down_on, ed[7:0]);
    chk(weak_up_on, m_weak[7:0]);
    @(posedge core_clk);
    rd(`BPP_OFF_IN_SAMPLE, ~ed);
  endtask
  task automatic regs;
    rd(`BPP_OFF_DIRECTION, m_dir);
    rd(`BPP_OFF_FUNC_SEL, m_sel);
    rd(`BPP_OFF_OUT_DATA, m_dat);
  endtask
  // ==========
  // Main sequence
  initial begin
    m_dir = 255; m_sel = 0; m_dat = 255; m_weak = 255;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk); chk(strong_high_on, 8'hFF);
    repeat (10) @(posedge core_clk);
    @(negedge core_clk); chk(strong_high_on, 8'h00);
    @(posedge core_clk);
    pins;
    regs;
    wr(`BPP_OFF_DIRECTION, 8'h0F);
    pins;
    for (i = 0; i < 24; i++) begin
      wr(`BPP_OFF_DIRECTION, $random(seed));
      wr(`BPP_OFF_FUNC_SEL, $random(seed));
      wr(`BPP_OFF_OUT_DATA, $random(seed));
      pdir <= 8'($random(seed));
      pval <= 8'($random(seed));
      pins;
      regs;
    end
    wr(`BPP_OFF_DIRECTION, 8'hFF);
    wr(`BPP_OFF_FUNC_SEL, 8'hFF);
    wr(`BPP_OFF_OUT_DATA, 8'hFF);
    pdir <= 8'hFF;
    pval <= 8'hFF;
    pins;
    wr(4'h2, 8'hA5);
    rd(4'h2, 0);
    regs;
    rst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk); chk(weak_up_on, 8'hFF);
    chk(strong_high_on, 8'hFF);
    @(posedge core_clk);
    rst_n <= 1'b1;
    m_dir = 255; m_sel = 0; m_dat = 255; m_weak = 255;
    repeat (16) @(posedge core_clk);
    @(negedge core_clk); chk(strong_high_on, 8'h00);
    @(posedge core_clk);
    pins;
    regs;
    summarize;
  end
  initial begin
    #100000;
    num_errors++;
    summarize;
  end
endmodule // tb_top
bind bpp_port_ctrl bpp_monitor #(.WIDTH(WIDTH)) mon (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .peripheral_direction(peripheral_direction),
  .peripheral_output_value(peripheral_output_value), .pin_in(pin_in),
  .pull_up_on(pull_up_on), .pull_down_on(pull_down_on), .strong_high_on(strong_high_on),
  .weak_up_on(weak_up_on));
